//--- logic/csr_params.svh
// Timing counts, reset values and field positions of the core state block
`ifndef CSR_PARAMS_SVH
`define CSR_PARAMS_SVH
// Overview of operation
// - Instruction pointer resets to zero, first fetch from lowest word.
// - Fetch handles one-word instructions and two-word 32-bit instructions.
// - Calls and interrupts save the return location as a word address.
// - Saving a return location lowers the stack pointer by two.
// - Return low byte is written first, at the higher stack address.
// - Subroutine and handler exit restore pointer, raise stack by two.
// - Stack pointer resets to the highest internal data SRAM address.
// - Stack grows downward: push lowers pointer, pop raises it.
// - Single-byte push lowers stack pointer by one, pop raises by one.
// - Low-byte stack write blocks interrupts four instructions or I/O write.
// - Stack pointer is two 8-bit registers reachable in I/O space.
// - Result flags update after every arithmetic or logic operation, unless an I/O write to them lands in the same cycle.
// - Result flags are never saved or restored on interrupt entry, exit.
// - Core runs on the undivided clock, up to one instruction per cycle.
// - Two-operand operation reads, computes and writes back in one cycle.
// - Register file holds 32 working registers of 8 bits each.
// - Port schemes: 8r/8w, two 8r/8w, two 8r/16w, 16r/16w.
// - Working registers live apart from data memory addresses.
// - Indices 0x1a to 0x1f form first, second and third pointer pairs.
// - Data access uses any pair; program load and indirect use third.
// - Lower index of a pair holds the low address byte.
// - Pointer modes: fixed displacement, auto increment, auto decrement.
// - Next instruction is prefetched while the current one executes.
// - Stack pointer high byte sits at the low-byte location plus one.
`define CSR_PC_RESET 16'h0000
`define CSR_SRAM_TOP 16'h3fff
`define CSR_SPL_ADDR 12'h03d
`define CSR_SPH_ADDR 12'h03e
`define CSR_RESULT_FLAGS_REGISTER_ADDR 12'h03f
`define CSR_HOLDOFF_INSNS 3'd4
`define CSR_PTR_FIRST 5'h1a
`define CSR_PTR_SECOND 5'h1c
`define CSR_PTR_THIRD 5'h1e
`endif

//--- logic/csr_pkg.sv
// Types shared by the core state block
package csr_pkg;
  typedef enum logic [3:0] {
    CSR_PM_NONE = 4'b0001,
    CSR_PM_DISP = 4'b0010,
    CSR_PM_INC = 4'b0100,
    CSR_PM_DEC = 4'b1000
  } csr_ptr_mode_e;
  typedef enum logic [4:0] {
    CSR_SK_IDLE = 5'b00001,
    CSR_SK_PUSH_LO = 5'b00010,
    CSR_SK_PUSH_HI = 5'b00100,
    CSR_SK_POP_HI = 5'b01000,
    CSR_SK_POP_LO = 5'b10000
  } csr_stack_e;
endpackage

//--- logic/csr_rf_if.sv
// Register file port bundle between core and register file
`timescale 1ns/1ns
interface csr_rf_if;
  logic [4:0] ra_idx;
  logic [4:0] rb_idx;
  logic [7:0] ra_data;
  logic [7:0] rb_data;
  logic [15:0] ra_word;
  logic [4:0] w_idx;
  logic [15:0] w_data;
  logic w_en;
  logic w_wide;
  logic [1:0] ptr_sel;
  logic [15:0] ptr_value;
  logic ptr_we;
  logic [15:0] ptr_new;
  modport core (output ra_idx, rb_idx, w_idx, w_data, w_en, w_wide,
    ptr_sel, ptr_we, ptr_new, input ra_data, rb_data, ra_word, ptr_value);
  modport file (input ra_idx, rb_idx, w_idx, w_data, w_en, w_wide,
    ptr_sel, ptr_we, ptr_new, output ra_data, rb_data, ra_word, ptr_value);
endinterface

//--- logic/csr_regfile.sv
// Thirty-two 8-bit working registers with byte and word ports
`timescale 1ns/1ns
`include "csr_params.svh"
module csr_regfile
(
  input wire logic clk, // Core clock
  csr_rf_if.file rf // Register ports
);
  import csr_pkg::*;
  logic [7:0] regs [0:31];
  logic [4:0] ra_hi;
  logic [4:0] ptr_lo;
  logic [4:0] w_hi;
  // Word reads take an even index and its odd neighbour
  assign ra_hi = {rf.ra_idx[4:1], 1'b1};
  assign rf.ra_data = regs[rf.ra_idx];
  assign rf.rb_data = regs[rf.rb_idx];
  assign rf.ra_word = {regs[ra_hi], regs[{rf.ra_idx[4:1], 1'b0}]};
  // Pointer pairs: lower index holds the low byte
  assign ptr_lo = (rf.ptr_sel == 2'd0) ? `CSR_PTR_FIRST :
    (rf.ptr_sel == 2'd1) ? `CSR_PTR_SECOND : `CSR_PTR_THIRD;
  assign rf.ptr_value = {regs[ptr_lo | 5'h01], regs[ptr_lo]};
  assign w_hi = {rf.w_idx[4:1], 1'b1};
  // Result write wins over pointer write-back on the same register
  always_ff @(posedge clk)
  begin
    if (rf.ptr_we)
    begin
      regs[ptr_lo] <= rf.ptr_new[7:0];
      regs[ptr_lo | 5'h01] <= rf.ptr_new[15:8];
    end
    if (rf.w_en && rf.w_wide)
    begin
      regs[{rf.w_idx[4:1], 1'b0}] <= rf.w_data[7:0];
      regs[w_hi] <= rf.w_data[15:8];
    end
    else if (rf.w_en)
      regs[rf.w_idx] <= rf.w_data[7:0];
  end
endmodule

//--- logic/csr_core.sv
// Core state: instruction pointer, stack, flags, pointer addressing
`timescale 1ns/1ns
`include "csr_params.svh"
module csr_core
#(
  parameter int PC_W = 16 // Program word address width
)
(
  input wire logic clk, // Core clock, undivided
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic [15:0] fetch_word, // Program word at fetch address
  input wire logic fetch_two_word, // Current word starts a 32-bit insn
  input wire logic insn_step, // An instruction completes this cycle
  input wire logic jump_en, // Load a new word address
  input wire logic [PC_W-1:0] jump_addr, // New word address
  input wire logic indirect_en, // Indirect invoke/branch via third pair
  input wire logic call_en, // Save return location (call or interrupt)
  input wire logic ret_en, // Subroutine or handler exit
  input wire logic push_en, // Single-byte push
  input wire logic pop_en, // Single-byte pop
  input wire logic [7:0] push_data, // Byte to push
  input wire logic [4:0] ra_idx, // First operand index
  input wire logic [4:0] rb_idx, // Second operand index
  input wire logic [4:0] w_idx, // Destination index
  input wire logic [15:0] w_data, // Result to write
  input wire logic w_en, // Write result
  input wire logic w_wide, // Result is 16 bits
  input wire logic alu_en, // ALU operation completes
  input wire logic [7:0] alu_flags, // Flags from that operation
  input wire logic ptr_en, // Pointer-addressed access
  input wire logic [1:0] ptr_sel, // Pair: 0 first, 1 second, 2 third
  input wire csr_pkg::csr_ptr_mode_e ptr_mode, // Addressing mode
  input wire logic [5:0] ptr_disp, // Fixed displacement
  input wire logic prog_load, // Program memory load access
  input wire logic io_we, // I/O write from software
  input wire logic [11:0] io_addr, // I/O address
  input wire logic [7:0] io_wdata, // I/O write data
  input wire logic [7:0] mem_rdata, // Data memory read byte
  output logic [PC_W-1:0] fetch_addr, // Program word to fetch
  output logic [15:0] insn_word, // Prefetched instruction
  output logic [15:0] insn_ext, // Second word of 32-bit insn
  output logic [15:0] ptr_addr, // Effective pointer address
  output logic [15:0] stack_addr, // Stack memory address
  output logic [7:0] stack_wdata, // Stack write byte
  output logic stack_we, // Stack write strobe
  output logic [7:0] ra_out, // First operand byte
  output logic [7:0] rb_out, // Second operand byte
  output logic [15:0] ra_word_out, // 16-bit operand
  output logic [7:0] io_rdata, // I/O read data
  output logic irq_block, // Interrupt acceptance held off
  output logic [7:0] result_flags_register // Status flags
);
  import csr_pkg::*;
  csr_rf_if rf();
  csr_regfile u_rf (.clk(clk), .rf(rf));
  logic [PC_W-1:0] instruction_pointer;
  logic [15:0] stack_top_pointer;
  csr_stack_e stk;
  logic [PC_W-1:0] ret_addr;
  logic [7:0] ret_hi;
  logic [2:0] holdoff;
  logic ext_pending;
  logic [15:0] ptr_inc;
  logic [15:0] ptr_dec;
  logic [15:0] next_ptr_addr;
  logic [PC_W-1:0] next_pc;
  logic [15:0] ret_word;
  logic spl_write;
  logic [15:0] next_sp;
  logic [7:0] next_io_rdata;

  function automatic logic [15:0] add16(input logic [15:0] a,
    input logic [15:0] b);
    add16 = a + b;
  endfunction

  // Register file hookup; indirect and program loads use the third pair
  assign rf.ra_idx = ra_idx;
  assign rf.rb_idx = rb_idx;
  assign rf.w_idx = w_idx;
  assign rf.w_data = w_data;
  assign rf.w_en = w_en;
  assign rf.w_wide = w_wide;
  assign rf.ptr_sel = (prog_load || indirect_en) ? 2'd2 : ptr_sel;
  assign ptr_inc = add16(rf.ptr_value, 16'h0001);
  assign ptr_dec = add16(rf.ptr_value, 16'hffff);
  assign rf.ptr_we = ptr_en && (ptr_mode == CSR_PM_INC ||
    ptr_mode == CSR_PM_DEC);
  assign rf.ptr_new = (ptr_mode == CSR_PM_INC) ? ptr_inc : ptr_dec;
  // Decrement mode accesses the lowered address; increment the old one
  assign next_ptr_addr = (ptr_mode == CSR_PM_DISP) ?
    add16(rf.ptr_value, {10'h000, ptr_disp}) :
    (ptr_mode == CSR_PM_DEC) ? ptr_dec : rf.ptr_value;

  // Next instruction pointer: 32-bit insns skip their extension word
  // High byte was taken first; the low byte arrives now from the higher slot
  assign ret_word = {ret_hi, mem_rdata};
  assign next_pc = indirect_en ? rf.ptr_value[PC_W-1:0] :
    jump_en ? jump_addr :
    (stk == CSR_SK_POP_LO) ? ret_word[PC_W-1:0] :
    fetch_two_word ? instruction_pointer + PC_W'(2) :
    instruction_pointer + PC_W'(1);

  assign spl_write = io_we && io_addr == `CSR_SPL_ADDR;
  // Stack pointer: software write, then push/pop/call/return stepping
  always_comb
  begin
    next_sp = stack_top_pointer;
    if (io_we && io_addr == `CSR_SPL_ADDR)
      next_sp = {stack_top_pointer[15:8], io_wdata};
    else if (io_we && io_addr == `CSR_SPH_ADDR)
      next_sp = {io_wdata, stack_top_pointer[7:0]};
    else if (push_en || stk == CSR_SK_PUSH_LO || stk == CSR_SK_PUSH_HI)
      next_sp = add16(stack_top_pointer, 16'hffff);
    else if (pop_en || stk == CSR_SK_POP_HI || stk == CSR_SK_POP_LO)
      next_sp = add16(stack_top_pointer, 16'h0001);
  end

  assign next_io_rdata = (io_addr == `CSR_SPL_ADDR) ? stack_top_pointer[7:0] :
    (io_addr == `CSR_SPH_ADDR) ? stack_top_pointer[15:8] :
    (io_addr == `CSR_RESULT_FLAGS_REGISTER_ADDR) ? result_flags_register : 8'h00;

  // Instruction pointer and prefetch; one instruction per clock
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      instruction_pointer <= PC_W'(`CSR_PC_RESET);
      fetch_addr <= PC_W'(`CSR_PC_RESET);
      insn_word <= 16'h0000;
      insn_ext <= 16'h0000;
      ext_pending <= 1'b0;
    end
    else if (insn_step || stk == CSR_SK_POP_LO)
    begin
      instruction_pointer <= next_pc;
      fetch_addr <= next_pc;
      insn_word <= fetch_word;
      ext_pending <= fetch_two_word;
    end
    else if (ext_pending)
    begin
      insn_ext <= fetch_word;
      ext_pending <= 1'b0;
    end
  end

  // Return-location save/restore sequencer
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      stk <= CSR_SK_IDLE;
      ret_addr <= '0;
      ret_hi <= 8'h00;
    end
    else
    begin
      case (stk)
        CSR_SK_IDLE:
        begin
          if (call_en)
          begin
            ret_addr <= instruction_pointer + PC_W'(1);
            stk <= CSR_SK_PUSH_LO;
          end
          else if (ret_en)
            stk <= CSR_SK_POP_HI;
        end
        CSR_SK_PUSH_LO: stk <= CSR_SK_PUSH_HI;
        CSR_SK_PUSH_HI: stk <= CSR_SK_IDLE;
        CSR_SK_POP_HI:
        begin
          ret_hi <= mem_rdata;
          stk <= CSR_SK_POP_LO;
        end
        CSR_SK_POP_LO: stk <= CSR_SK_IDLE;
        default: stk <= CSR_SK_IDLE;
      endcase
    end
  end

  // Stack memory strobes; low byte goes first at the higher address
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      stack_top_pointer <= `CSR_SRAM_TOP;
      stack_addr <= 16'h0000;
      stack_wdata <= 8'h00;
      stack_we <= 1'b0;
    end
    else
    begin
      stack_top_pointer <= next_sp;
      // The pointer only moves up as this address launches, so look two ahead
      stack_addr <= (stk == CSR_SK_POP_HI) ?
        add16(stack_top_pointer, 16'h0002) :
        (stk == CSR_SK_POP_LO || (stk == CSR_SK_IDLE && (pop_en || ret_en))) ?
        add16(stack_top_pointer, 16'h0001) : stack_top_pointer;
      stack_we <= push_en || stk == CSR_SK_PUSH_LO || stk == CSR_SK_PUSH_HI;
      stack_wdata <= (stk == CSR_SK_PUSH_LO) ? 8'(ret_addr) :
        (stk == CSR_SK_PUSH_HI) ? 8'(ret_addr >> 8) : push_data;
    end
  end

  // Hold-off after low-byte write; next I/O write ends it early
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      holdoff <= 3'd0;
    else if (spl_write)
      holdoff <= `CSR_HOLDOFF_INSNS;
    else if (io_we)
      holdoff <= 3'd0;
    else if (insn_step && holdoff != 3'd0)
      holdoff <= holdoff - 3'd1;
  end

  // Flags follow each ALU result or an I/O write, which wins; interrupt entry leaves them alone
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      result_flags_register <= 8'h00;
    else if (io_we && io_addr == `CSR_RESULT_FLAGS_REGISTER_ADDR)
      result_flags_register <= io_wdata;
    else if (alu_en)
      result_flags_register <= alu_flags;
  end

  // Registered outputs for operands, pointer address and I/O reads
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      ra_out <= 8'h00;
      rb_out <= 8'h00;
      ra_word_out <= 16'h0000;
      ptr_addr <= 16'h0000;
      io_rdata <= 8'h00;
      irq_block <= 1'b0;
    end
    else
    begin
      ra_out <= rf.ra_data;
      rb_out <= rf.rb_data;
      ra_word_out <= rf.ra_word;
      ptr_addr <= next_ptr_addr;
      io_rdata <= next_io_rdata;
      // Any other I/O write ends the hold-off in the same cycle
      irq_block <= spl_write || (!io_we && ((holdoff > 3'd1) ||
        (holdoff == 3'd1 && !insn_step)));
    end
  end
endmodule

//--- verification/csr_core_checker.sv
// Concurrent checks on the core state block ports
`timescale 1ns/1ns
`include "csr_params.svh"
module csr_core_checker
#(
  parameter int PC_W = 16 // Program word address width
)
(
  input wire logic clk, // Core clock
  input wire logic reset_n, // Sync reset, active low
  input wire logic call_en, // Return save request
  input wire logic push_en, // Byte push request
  input wire logic [7:0] push_data, // Byte to push
  input wire logic insn_step, // Instruction retired
  input wire logic alu_en, // ALU result strobe
  input wire logic [7:0] alu_flags, // ALU flags
  input wire logic io_we, // I/O write strobe
  input wire logic [11:0] io_addr, // I/O address
  input wire logic [PC_W-1:0] fetch_addr, // Fetch word address
  input wire logic [15:0] stack_addr, // Stack address
  input wire logic [7:0] stack_wdata, // Stack write byte
  input wire logic stack_we, // Stack write strobe
  input wire logic irq_block, // Interrupt hold-off
  input wire logic [7:0] result_flags_register // Status flags
);
  logic [2:0] step_cnt;
  // Software writes that steer hold-off and flags
  wire spl_wr = io_we && io_addr == `CSR_SPL_ADDR;
  wire result_flags_register_wr = io_we && io_addr == `CSR_RESULT_FLAGS_REGISTER_ADDR;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // Steps retired while held off; a fresh low-byte write restarts it
  always_ff @(posedge clk)
    if (!reset_n || spl_wr)
      step_cnt <= 3'h0;
    else if (irq_block && insn_step)
      step_cnt <= step_cnt + 3'h1;
  a_reset_ptr_zero:
  assert property ($rose(reset_n) |-> !(|fetch_addr))
    else $error("fetch address not zero after reset");
  a_push_one_byte:
  assert property (push_en |=> stack_we && stack_wdata == $past(push_data))
    else $error("push did not store its byte");
  a_call_two_bytes:
  assert property (call_en |=> ##1 stack_we ##1
    (stack_we && stack_addr == $past(stack_addr) - 16'h1))
    else $error("return save is not two bytes downward");
  a_spl_holdoff:
  assert property (spl_wr |=> irq_block)
    else $error("low byte write did not hold off interrupts");
  a_holdoff_clear:
  assert property (irq_block && io_we && !spl_wr |=> !irq_block)
    else $error("I/O write did not end hold-off");
  a_holdoff_hold:
  assert property (irq_block && !io_we && !insn_step |=> irq_block)
    else $error("hold-off ended without cause");
  a_holdoff_steps:
  assert property (irq_block |-> step_cnt < 3'h4)
    else $error("hold-off outlasted four instructions");
  a_flags_follow:
  assert property (alu_en && !result_flags_register_wr |=>
    result_flags_register == $past(alu_flags))
    else $error("flags did not follow the ALU");
  a_flags_hold:
  assert property (!alu_en && !result_flags_register_wr |=> $stable(result_flags_register))
    else $error("flags changed without an ALU operation");
  // Main scenarios reached
  cover property (call_en ##2 stack_we);
  cover property ($fell(irq_block));
  cover property (push_en ##1 stack_we);
endmodule
bind csr_core csr_core_checker #(.PC_W(PC_W)) u_checker (.clk(clk),
  .reset_n(reset_n), .call_en(call_en), .push_en(push_en),
  .push_data(push_data), .insn_step(insn_step), .alu_en(alu_en),
  .alu_flags(alu_flags), .io_we(io_we), .io_addr(io_addr),
  .fetch_addr(fetch_addr), .stack_addr(stack_addr),
  .stack_wdata(stack_wdata), .stack_we(stack_we), .irq_block(irq_block),
  .result_flags_register(result_flags_register));

//--- verification/test_cpu_stack_and_register_file.sv
// Self-checking bench for the core state block
`timescale 1ns/1ns
`include "csr_params.svh"
module test_cpu_stack_and_register_file;
  import csr_pkg::*;
  typedef struct {logic [15:0] a; logic [7:0] d; logic dk;} csr_note_s;
  localparam logic [15:0] top = `CSR_SRAM_TOP;
  localparam logic [9:0] op_step = 10'h001, op_alu = 10'h002,
    op_pop = 10'h004, op_push = 10'h008, op_ret = 10'h010,
    op_call = 10'h020, op_ind = 10'h040, op_ptr = 10'h100, op_wen = 10'h200;
  logic clk, reset_n, fetch_two_word, insn_step, jump_en, indirect_en;
  logic call_en, ret_en, push_en, pop_en, w_en, w_wide, alu_en, ptr_en;
  logic prog_load, io_we, stack_we, irq_block;
  logic [15:0] fetch_word, jump_addr, w_data, insn_word, insn_ext, r16;
  logic [15:0] fetch_addr, ptr_addr, stack_addr, ra_word_out;
  logic [7:0] push_data, alu_flags, io_wdata, mem_rdata, stack_wdata, r8;
  logic [7:0] ra_out, rb_out, io_rdata, flags, mem [16];
  logic [4:0] ra_idx, rb_idx, w_idx, ix;
  logic [1:0] ptr_sel;
  logic [5:0] ptr_disp;
  logic [11:0] io_addr;
  logic [9:0] op;
  csr_ptr_mode_e ptr_mode;
  csr_note_s notes[$], nt;
  int mismatches, n_compared, seed;
  assign {w_en, ptr_en, jump_en, indirect_en, call_en, ret_en, push_en,
    pop_en, alu_en, insn_step} = op;
  // Stack reads return what was stored, so a wrong address shows up
  assign mem_rdata = mem[stack_addr[3:0]];
  csr_core dut (.clk(clk), .reset_n(reset_n), .fetch_word(fetch_word),
    .fetch_two_word(fetch_two_word), .insn_step(insn_step),
    .jump_en(jump_en), .jump_addr(jump_addr), .indirect_en(indirect_en),
    .call_en(call_en), .ret_en(ret_en), .push_en(push_en), .pop_en(pop_en),
    .push_data(push_data), .ra_idx(ra_idx), .rb_idx(rb_idx), .w_idx(w_idx),
    .w_data(w_data), .w_en(w_en), .w_wide(w_wide), .alu_en(alu_en),
    .alu_flags(alu_flags), .ptr_en(ptr_en), .ptr_sel(ptr_sel),
    .ptr_mode(ptr_mode), .ptr_disp(ptr_disp), .prog_load(prog_load),
    .io_we(io_we), .io_addr(io_addr), .io_wdata(io_wdata),
    .mem_rdata(mem_rdata), .fetch_addr(fetch_addr), .insn_word(insn_word),
    .insn_ext(insn_ext), .ptr_addr(ptr_addr), .stack_addr(stack_addr),
    .stack_wdata(stack_wdata), .stack_we(stack_we), .ra_out(ra_out),
    .rb_out(rb_out), .ra_word_out(ra_word_out), .io_rdata(io_rdata),
    .irq_block(irq_block), .result_flags_register(flags));
  task automatic chk(string n, logic [15:0] e, logic [15:0] s);
    n_compared++;
    if (s !== e)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // One-cycle strobe; a low cycle always follows so strobes never merge
  task automatic pulse(logic [9:0] m, int gap);
    @(posedge clk);
    op <= m;
    @(posedge clk);
    op <= 10'h0;
    repeat (gap) @(posedge clk);
  endtask
  task automatic io_wr(logic [11:0] a, logic [7:0] d);
    @(posedge clk);
    io_we <= 1'b1;
    io_addr <= a;
    io_wdata <= d;
    @(posedge clk);
    io_we <= 1'b0;
  endtask
  task automatic io_rd(logic [11:0] a, logic [7:0] e, string n);
    @(posedge clk);
    io_addr <= a;
    repeat (2) @(posedge clk);
    #1;
    chk(n, {8'h0, e}, {8'h0, io_rdata});
  endtask
  task automatic sp_chk(logic [15:0] e);
    io_rd(`CSR_SPL_ADDR, e[7:0], "sp_low");
    io_rd(`CSR_SPH_ADDR, e[15:8], "sp_high");
  endtask
  task automatic wr(logic [4:0] i, logic [15:0] d, logic wd);
    w_idx <= i;
    w_data <= d;
    w_wide <= wd;
    pulse(op_wen, 1);
  endtask
  task automatic rd(logic [4:0] i, logic [15:0] e);
    ra_idx <= i;
    rb_idx <= i + 5'h1;
    repeat (3) @(posedge clk);
    #1;
    chk("ra_word_out", e, ra_word_out);
    chk("pair_bytes", e, {rb_out, ra_out});
  endtask
  // Waits a bounded time for the pointer to settle on a new value
  task automatic poll_fetch(logic [15:0] e);
    #1;
    for (int i = 0; i < 8 && fetch_addr !== e; i++)
      #100;
    chk("fetch_addr", e, fetch_addr);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Every stack write is matched with the oldest note
  always @(posedge clk)
    if (reset_n && stack_we === 1'b1)
    begin
      mem[stack_addr[3:0]] <= stack_wdata;
      if (notes.size() == 0)
        chk("stack_we", 16'h0, 16'h1);
      else
      begin
        nt = notes.pop_front();
        chk("stack_addr", nt.a, stack_addr);
        if (nt.dk)
          chk("stack_wdata", {8'h0, nt.d}, {8'h0, stack_wdata});
      end
    end
  // Cuts a hang short well past the expected run length
  initial
  begin
    #(100 * 5000);
    mismatches++;
    end_sim();
  end
  initial
  begin
    seed = 44565;
    op = 10'h0;
    reset_n = 1'b0;
    {fetch_two_word, w_wide, prog_load, io_we} = 4'h0;
    {jump_addr, w_data, push_data, alu_flags, io_wdata} = 56'h0;
    {ra_idx, rb_idx, w_idx, ptr_sel, ptr_disp, io_addr} = 35'h0;
    ptr_mode = CSR_PM_NONE;
    fetch_word = 16'($random(seed));
    foreach (mem[i])
      mem[i] = 8'h0;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    #1;
    chk("fetch_addr", 16'h0, fetch_addr);
    sp_chk(top);
    r8 = 8'($random(seed));
    push_data <= r8;
    notes.push_back('{top, r8, 1'b1});
    pulse(op_push, 2);
    sp_chk(top - 16'h1);
    pulse(op_pop, 2);
    sp_chk(top);
    repeat (3)
    begin
      r8 = 8'($random(seed));
      alu_flags <= r8;
      pulse(op_alu, 0);
      #1;
      chk("flags", {8'h0, r8}, {8'h0, flags});
    end
    io_rd(`CSR_RESULT_FLAGS_REGISTER_ADDR, r8, "flags_io");
    // Call, then return through a planted word; flags must survive
    notes.push_back('{top, 8'h0, 1'b0});
    notes.push_back('{top - 16'h1, 8'h0, 1'b0});
    pulse(op_call, 4);
    sp_chk(top - 16'h2);
    r16 = 16'($random(seed));
    mem[4'hf] = r16[7:0];
    mem[4'he] = r16[15:8];
    pulse(op_ret, 0);
    poll_fetch(r16);
    chk("flags", {8'h0, r8}, {8'h0, flags});
    sp_chk(top);
    // Hold-off ends after four steps, or at once on another I/O write
    io_wr(`CSR_SPL_ADDR, 8'hf0);
    repeat (3) pulse(op_step, 0);
    #1;
    chk("irq_block", 16'h1, {15'h0, irq_block});
    pulse(op_step, 1);
    #1;
    chk("irq_block", 16'h0, {15'h0, irq_block});
    io_wr(`CSR_SPL_ADDR, top[7:0]);
    io_wr(`CSR_SPH_ADDR, top[15:8]);
    #1;
    chk("irq_block", 16'h0, {15'h0, irq_block});
    sp_chk(top);
    repeat (4)
    begin
      r16 = 16'($random(seed));
      ix = {4'($random(seed)), 1'b0};
      wr(ix, {8'h0, r16[7:0]}, 1'b0);
      wr(ix + 5'h1, {8'h0, r16[15:8]}, 1'b0);
      rd(ix, r16);
    end
    // Every pair in every mode; the third pair only as program load
    for (int s = 0; s < 3; s++)
    begin
      r16 = 16'($random(seed));
      ix = `CSR_PTR_FIRST + 5'(2 * s);
      wr(ix, r16, 1'b1);
      ptr_sel <= 2'(s);
      prog_load <= (s == 2);
      for (int m = 0; m < 4; m++)
      begin
        ptr_mode <= csr_ptr_mode_e'(4'h1 << m);
        ptr_disp <= 6'h15;
        pulse(op_ptr, 0);
        #1;
        chk("ptr_addr", r16 + (m == 1 ? 16'h15 : 16'h0), ptr_addr);
        rd(ix, r16 + 16'(m == 2));
      end
    end
    pulse(op_ind | op_step, 0);
    poll_fetch(r16);
    chk("insn_word", fetch_word, insn_word);
    // A two-word instruction skips its extension and latches it next cycle
    fetch_two_word <= 1'b1;
    pulse(op_step, 0);
    #1;
    chk("fetch_addr", r16 + 16'h2, fetch_addr);
    fetch_two_word <= 1'b0;
    @(posedge clk);
    #1;
    chk("insn_ext", fetch_word, insn_ext);
    chk("notes_left", 16'h0, 16'(notes.size()));
    end_sim();
  end
endmodule
